// File: hw/csp_pkg.sv
package csp_pkg;

  // ---------------------------------------------------------------------------
  // Modes and carriers
  // ---------------------------------------------------------------------------

  // Configuration source; only the flash source makes the port a master.
  typedef enum logic [1:0] {
    CSP_MODE_FLASH,
    CSP_MODE_MCU,
    CSP_MODE_OTP_RD,
    CSP_MODE_OTP_WR
  } csp_cfg_mode_e;

  // Clock polarity and phase, together one of the four serial modes.
  typedef struct packed {
    logic cpol;
    logic cpha;
  } csp_spi_mode_s;

  // Flash read request: command byte, start address and data length in bytes.
  typedef struct packed {
    logic [7:0]  cmd;
    logic [23:0] addr;
    logic [15:0] len;
  } csp_flash_req_s;

  // Master sequencer states.
  typedef enum logic [1:0] {
    CSP_M_IDLE,
    CSP_M_LEAD,
    CSP_M_CLK,
    CSP_M_TAIL
  } csp_mst_e;

  // ---------------------------------------------------------------------------
  // Timing and counts
  // ---------------------------------------------------------------------------

  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SCK_HALF_NS   = 40;
  localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DIV_W         = 3;
  localparam logic [2:0]  DIV_LAST      = 3'(SCK_HALF_CYC - 1);
  localparam int          CNT_W         = 20;
  localparam int          TX_W          = 32;
  localparam logic [19:0] HDR_BITS      = 20'h00020;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  localparam logic [23:0] TX_PAD        = 24'h000000;
  localparam int          SYNC_STAGES   = 2;

endpackage

// File: hw/csp_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for a bundle of independent levels.
module csp_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,  // Sampling clock.
  input  wire logic         rst,       // Asynchronous reset, active high.
  input  wire logic [W-1:0] d,         // Levels from another domain.
  output logic      [W-1:0] q          // Synchronised levels.
);

  logic [W-1:0] meta_ff;

  // ---------------------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------------------

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// File: hw/csp_top.sv
`timescale 1ns/1ps

// Behaviour
// - Flash mode master; other modes slave.
// - Four serial pins carry configuration traffic.
// - Separate config-done output pin.
// - Master makes clock; slave never drives it.
// - Master data out, slave captures it.
// - Slave data back, master collects it.
// - Active-low select; slave works only selected.
// - Polarity sets clock idle level.
// - Phase alone picks sample/shift edges.
// - Mode 0: idle low, sample rising.
// - Modes 1, 3: sample falling edge.
// - Mode 2: idle high, sample rising.
module csp_top (
  input  wire logic                    core_clk,        // Core clock, 100 MHz.
  input  wire logic                    rst,             // Asynchronous reset, active high.
  input  csp_pkg::csp_cfg_mode_e       cfg_mode,        // Configuration source.
  input  csp_pkg::csp_spi_mode_s       spi_mode,        // Clock polarity and phase.
  input  csp_pkg::csp_flash_req_s      flash_req,       // Flash read command, address, length.
  input  wire logic                    load_start,      // Pulse: start a flash load.
  input  wire logic                    load_done,       // Level: configuration complete.
  input  wire logic [7:0]              tx_byte,         // Next byte returned as slave.
  output logic                         tx_taken,        // Pulse: tx_byte was taken.
  output logic      [7:0]              rd_data,         // Last received byte.
  output logic                         rd_valid,        // Pulse: rd_data is new.
  output logic                         busy,            // Transfer in progress.
  output logic                         master_done,     // Pulse: flash load finished.
  input  wire logic                    sck_i,           // Serial clock pin, input side.
  output logic                         sck_o,           // Serial clock pin, output side.
  output logic                         sck_oe,          // Serial clock pin, drive enable.
  input  wire logic                    ss_n_i,          // Chip select pin, input side.
  output logic                         ss_n_o,          // Chip select pin, output side.
  output logic                         ss_n_oe,         // Chip select pin, drive enable.
  input  wire logic                    si_i,            // Serial data input pin.
  output logic                         so_o,            // Serial data output pin.
  output logic                         so_oe,           // Serial data output drive enable.
  output logic                         config_done_pin  // Configuration done pin.
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------

  csp_pkg::csp_mst_e                state_ff;
  csp_pkg::csp_mst_e                nxt_state;
  logic [csp_pkg::DIV_W-1:0]        div_ff;
  logic [csp_pkg::DIV_W-1:0]        nxt_div;
  logic                             sck_ff;
  logic                             nxt_sck;
  logic                             ss_n_ff;
  logic                             nxt_ss_n;
  logic [csp_pkg::TX_W-1:0]         tx_ff;
  logic [csp_pkg::TX_W-1:0]         nxt_tx;
  logic [7:0]                       rx_ff;
  logic [7:0]                       nxt_rx;
  logic [2:0]                       bit_ff;
  logic [2:0]                       nxt_bit;
  logic [csp_pkg::CNT_W-1:0]        total_ff;
  logic [csp_pkg::CNT_W-1:0]        nxt_total;
  logic [7:0]                       rd_data_ff;
  logic [7:0]                       nxt_rd_data;
  logic                             rd_valid_ff;
  logic                             nxt_rd_valid;
  logic                             taken_ff;
  logic                             nxt_taken;
  logic                             done_ff;
  logic                             nxt_done;
  logic                             cfg_done_ff;
  logic                             nxt_cfg_done;
  logic                             sck_d_ff;
  logic                             nxt_sck_d;
  logic                             sel_d_ff;
  logic                             nxt_sel_d;

  logic [2:0]                       pins_s;
  logic                             sck_s;
  logic                             ss_n_s;
  logic                             si_s;
  logic                             is_master;
  logic                             selected;
  logic                             tick;
  logic                             m_new;
  logic                             m_edge;
  logic                             s_rise;
  logic                             s_fall;
  logic                             samp_rise;
  logic                             sample_evt;
  logic                             shift_evt;
  logic                             sel_start;
  logic [csp_pkg::CNT_W-1:0]        goal;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------

  // Clock, select and data pins come from outside and pass two flops.
  csp_sync #(
    .W (3)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({sck_i, ss_n_i, si_i}),
    .q        (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign ss_n_s = pins_s[1];
  assign si_s   = pins_s[0];

  // ---------------------------------------------------------------------------
  // Edge decode
  // ---------------------------------------------------------------------------

  assign is_master = (cfg_mode == csp_pkg::CSP_MODE_FLASH);
  assign selected  = !is_master && !ss_n_s;
  assign sel_start = selected && !sel_d_ff;

  // Half-period divider tick and the level the master clock moves to.
  assign tick   = (div_ff == csp_pkg::DIV_LAST);
  assign m_new  = !sck_ff;
  assign m_edge = is_master && (state_ff == csp_pkg::CSP_M_CLK) && tick;

  assign s_rise = selected && sck_s && !sck_d_ff;
  assign s_fall = selected && !sck_s && sck_d_ff;

  assign samp_rise = !spi_mode.cpha;

  // Sample and shift events, from the master generator or the slave decode.
  assign sample_evt = (m_edge && (m_new == samp_rise))
                    || (s_rise && samp_rise)
                    || (s_fall && !samp_rise);
  assign shift_evt  = (m_edge && (m_new != samp_rise))
                    || (s_rise && !samp_rise)
                    || (s_fall && samp_rise);

  // Samples in a flash load: header bits plus eight per data byte.
  assign goal = csp_pkg::HDR_BITS + {1'b0, flash_req.len, 3'h0};

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Sequencer, shifters, counters and strobes.
  always_comb begin
    nxt_state    = state_ff;
    nxt_sck      = sck_ff;
    nxt_ss_n     = ss_n_ff;
    nxt_tx       = tx_ff;
    nxt_rx       = rx_ff;
    nxt_bit      = bit_ff;
    nxt_total    = total_ff;
    nxt_rd_data  = rd_data_ff;
    nxt_rd_valid = 1'b0;
    nxt_taken    = 1'b0;
    nxt_done     = 1'b0;
    nxt_sck_d    = sck_s;
    nxt_sel_d    = selected;
    nxt_cfg_done = load_done;
    nxt_div      = (state_ff == csp_pkg::CSP_M_IDLE || tick) ? '0 : div_ff + 1'b1;

    case (state_ff)
      csp_pkg::CSP_M_IDLE: begin
        nxt_sck  = spi_mode.cpol;
        nxt_ss_n = 1'b1;
        if (is_master && load_start && (flash_req.len != '0)) begin
          nxt_ss_n  = 1'b0;
          nxt_tx    = {flash_req.cmd, flash_req.addr};
          nxt_bit   = csp_pkg::BIT_FIRST;
          nxt_total = '0;
          nxt_state = csp_pkg::CSP_M_LEAD;
        end
      end
      csp_pkg::CSP_M_LEAD: begin
        if (tick) begin
          nxt_state = csp_pkg::CSP_M_CLK;
        end
      end
      csp_pkg::CSP_M_CLK: begin
        if (tick) begin
          nxt_sck = m_new;
          if (sample_evt && (total_ff + 1'b1 == goal)) begin
            nxt_state = csp_pkg::CSP_M_TAIL;
          end
        end
      end
      csp_pkg::CSP_M_TAIL: begin
        if (tick) begin
          if (sck_ff != spi_mode.cpol) begin
            nxt_sck = !sck_ff;
          end else begin
            nxt_ss_n  = 1'b1;
            nxt_done  = 1'b1;
            nxt_state = csp_pkg::CSP_M_IDLE;
          end
        end
      end
      default: begin
        nxt_state = csp_pkg::CSP_M_IDLE;
      end
    endcase

    if (!is_master && !selected) begin
      nxt_bit   = csp_pkg::BIT_FIRST;
      nxt_total = '0;
    end

    // Slave preloads the first return byte when it is selected.
    if (sel_start) begin
      nxt_tx    = {tx_byte, csp_pkg::TX_PAD};
      nxt_taken = 1'b1;
    end

    if (sample_evt) begin
      nxt_rx    = {rx_ff[6:0], si_s};
      nxt_bit   = bit_ff + 1'b1;
      nxt_total = total_ff + 1'b1;
      if (bit_ff == csp_pkg::BIT_LAST && (!is_master || total_ff >= csp_pkg::HDR_BITS)) begin
        nxt_rd_data  = {rx_ff[6:0], si_s};
        nxt_rd_valid = 1'b1;
      end
    end

    if (shift_evt && (total_ff != '0)) begin
      if (!is_master && bit_ff == csp_pkg::BIT_FIRST) begin
        nxt_tx    = {tx_byte, csp_pkg::TX_PAD};
        nxt_taken = 1'b1;
      end else begin
        nxt_tx = {tx_ff[csp_pkg::TX_W-2:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------

  // State registers only.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= csp_pkg::CSP_M_IDLE;
      div_ff      <= '0;
      sck_ff      <= 1'b0;
      ss_n_ff     <= 1'b1;
      tx_ff       <= '0;
      rx_ff       <= '0;
      bit_ff      <= '0;
      total_ff    <= '0;
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
      taken_ff    <= 1'b0;
      done_ff     <= 1'b0;
      cfg_done_ff <= 1'b0;
      sck_d_ff    <= 1'b0;
      sel_d_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      div_ff      <= nxt_div;
      sck_ff      <= nxt_sck;
      ss_n_ff     <= nxt_ss_n;
      tx_ff       <= nxt_tx;
      rx_ff       <= nxt_rx;
      bit_ff      <= nxt_bit;
      total_ff    <= nxt_total;
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      taken_ff    <= nxt_taken;
      done_ff     <= nxt_done;
      cfg_done_ff <= nxt_cfg_done;
      sck_d_ff    <= nxt_sck_d;
      sel_d_ff    <= nxt_sel_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  assign sck_o   = sck_ff;
  assign sck_oe  = is_master;
  assign ss_n_o  = ss_n_ff;
  assign ss_n_oe = is_master;
  assign so_o    = tx_ff[csp_pkg::TX_W-1];
  assign so_oe   = is_master ? (state_ff != csp_pkg::CSP_M_IDLE) : selected;

  // User-side strobes and status.
  assign rd_data         = rd_data_ff;
  assign rd_valid        = rd_valid_ff;
  assign tx_taken        = taken_ff;
  assign master_done     = done_ff;
  assign busy            = (state_ff != csp_pkg::CSP_M_IDLE) || selected;
  assign config_done_pin = cfg_done_ff;

endmodule

// File: verification/csp_top_monitor.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------------

// Watches the pin roles, serial timing and strobes of the port.
module csp_top_monitor (
  input wire logic               core_clk,        // Core clock.
  input wire logic               rst,             // Asynchronous reset.
  input csp_pkg::csp_cfg_mode_e  cfg_mode,        // Configuration source.
  input csp_pkg::csp_spi_mode_s  spi_mode,        // Polarity and phase.
  input csp_pkg::csp_flash_req_s flash_req,       // Flash request.
  input wire logic               load_start,      // Load request.
  input wire logic               load_done,       // Core done level.
  input wire logic               busy,            // Transfer in progress.
  input wire logic               master_done,     // Load finished.
  input wire logic               sck_o,           // Clock out.
  input wire logic               sck_oe,          // Clock drive enable.
  input wire logic               ss_n_i,          // Select in.
  input wire logic               ss_n_o,          // Select out.
  input wire logic               ss_n_oe,         // Select drive enable.
  input wire logic               so_o,            // Data out.
  input wire logic               so_oe,           // Data drive enable.
  input wire logic               config_done_pin  // Done pin.
);
  logic mst;

  // High while the port is the master.
  assign mst = (cfg_mode == csp_pkg::CSP_MODE_FLASH);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pin_roles_a: assert property (sck_oe == mst && ss_n_oe == mst)
    else $error("Clock or select drive does not follow the source.");
  idle_level_a: assert property (mst && $past(mst) && ss_n_o && $past(ss_n_o) &&
    $stable(spi_mode) && !$past(rst) |-> sck_o == spi_mode.cpol)
    else $error("Idle clock level differs from polarity.");
  lead_quiet_a: assert property (mst && $fell(ss_n_o) |-> (sck_o == spi_mode.cpol) [*3])
    else $error("Clock moved too soon after select.");
  half_period_a: assert property (mst && !ss_n_o && $changed(sck_o) |=> $stable(sck_o) [*3])
    else $error("Clock half period too short.");
  start_select_a: assert property (mst && load_start && !busy &&
    flash_req.len != 16'h0000 |=> !ss_n_o)
    else $error("Load did not select the flash.");
  refuse_empty_a: assert property (mst && load_start && !busy && ss_n_o &&
    flash_req.len == 16'h0000 |=> ss_n_o)
    else $error("Empty load selected the flash.");
  mosi_hold_a: assert property (mst && !ss_n_o &&
    (spi_mode.cpha ? $fell(sck_o) : $rose(sck_o)) |-> $stable(so_o))
    else $error("Data changed on the sample edge.");
  done_frame_a: assert property (mst && $rose(ss_n_o) |-> master_done && !so_oe)
    else $error("Deselect without done strobe.");
  drive_frame_a: assert property (mst && !ss_n_o |-> so_oe && busy)
    else $error("Data line not driven in frame.");
  slave_quiet_a: assert property (!mst && $past(cfg_mode) != csp_pkg::CSP_MODE_FLASH &&
    ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) && $past(ss_n_i, 3) |-> !so_oe && !sck_oe)
    else $error("Deselected slave drives a line.");
  done_copy_a: assert property (1'b1 |=> config_done_pin == $past(load_done))
    else $error("Done pin does not follow the core.");
endmodule

bind csp_top csp_top_monitor csp_top_monitor_inst (
  .core_clk(core_clk), .rst(rst), .cfg_mode(cfg_mode), .spi_mode(spi_mode),
  .flash_req(flash_req), .load_start(load_start), .load_done(load_done), .busy(busy),
  .master_done(master_done), .sck_o(sck_o), .sck_oe(sck_oe), .ss_n_i(ss_n_i),
  .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .so_o(so_o), .so_oe(so_oe),
  .config_done_pin(config_done_pin));

// File: verification/csp_flash_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Serial flash stand-in
// ---------------------------------------------------------------------------

// Records 32 header bits, then answers base, base+1 and on, MSB first.
module csp_flash_model (
  input  wire logic        sck,   // Serial clock, only received here.
  input  wire logic        ss_n,  // Active-low select.
  input  wire logic        mosi,  // Data from the master.
  input  wire logic        cpha,  // Clock phase in use.
  input  wire logic [7:0]  base,  // First data byte.
  output logic             miso,  // Data to the master.
  output logic      [31:0] hdr    // Captured command and address.
);
  int   n_smp = 0;
  logic sck_q = 1'b0;

  // Starts both outputs at known values.
  initial begin
    miso = 1'b0;
    hdr  = 32'h00000000;
  end

  always @(sck or ss_n) begin : edge_proc
    logic [7:0] b;
    int         k;
    k = n_smp - 32;
    b = base + 8'(k / 8);
    if (ss_n) begin
      n_smp = 0;
      miso  = ~miso;  // Released line shows the inverse of its last value.
    end else if (sck !== sck_q) begin
      if (sck == !cpha) begin
        if (n_smp < 32) hdr = {hdr[30:0], mosi};
        n_smp++;
      end else begin
        miso = (k >= 0) ? b[7 - k % 8] : ~miso;
      end
    end
    sck_q = sck;
  end
endmodule

// File: verification/csp_top_test.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Bench for the configuration serial port
// ---------------------------------------------------------------------------

module csp_top_test;
  logic                    core_clk, rst, load_start, load_done, tx_taken, rd_valid, busy;
  logic                    master_done, sck_o, sck_oe, ss_n_o, ss_n_oe, so_o, so_oe;
  logic                    config_done_pin, sck_h, ss_h, si_h, f_miso, sck_w, ss_w, si_w;
  logic [7:0]              tx_byte, rd_data, base;
  logic [31:0]             hdr;
  csp_pkg::csp_cfg_mode_e  cfg_mode;
  csp_pkg::csp_spi_mode_s  spi_mode;
  csp_pkg::csp_flash_req_s flash_req;
  logic [1:0]              mtab [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [7:0]              exp_q [$];
  int                      n_mismatch = 0, checks_done = 0, cyc = 0, m, n_taken = 0;

  // Pin levels from whichever party drives each line.
  assign sck_w = sck_oe ? sck_o : sck_h;
  assign ss_w  = ss_n_oe ? ss_n_o : ss_h;
  assign si_w  = (cfg_mode == csp_pkg::CSP_MODE_FLASH) ? f_miso : si_h;

  csp_top csp_top_inst (.core_clk(core_clk), .rst(rst), .cfg_mode(cfg_mode),
    .spi_mode(spi_mode), .flash_req(flash_req), .load_start(load_start),
    .load_done(load_done), .tx_byte(tx_byte), .tx_taken(tx_taken), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .master_done(master_done), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe(sck_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
    .si_i(si_w), .so_o(so_o), .so_oe(so_oe), .config_done_pin(config_done_pin));

  csp_flash_model csp_flash_model_inst (.sck(sck_w), .ss_n(ss_w), .mosi(so_o),
    .cpha(spi_mode.cpha), .base(base), .miso(f_miso), .hdr(hdr));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One flash load of two bytes in serial mode mtab[m].
  task automatic flash_load(input int m);
    csp_pkg::csp_flash_req_s r;
    logic [7:0]              b;
    int                      w;
    r = '{8'($urandom), 24'($urandom), 16'h0002};
    b = 8'($urandom);
    exp_q.push_back(b);
    exp_q.push_back(b + 8'h01);
    cfg_mode  <= csp_pkg::CSP_MODE_FLASH;
    spi_mode  <= csp_pkg::csp_spi_mode_s'(mtab[m]);
    flash_req <= r;
    base      <= b;
    repeat (2) @(posedge core_clk);
    load_start <= 1'b1;
    @(posedge core_clk);
    load_start <= 1'b0;
    w = 0;
    while (master_done !== 1'b1 && w < 2000) begin
      @(posedge core_clk);
      w++;
    end
    check("load finished", 32'(w < 2000), 32'h1);
    check("flash header", hdr, {r.cmd, r.addr});
  endtask

  // One byte each way with the port as slave in serial mode mtab[m].
  task automatic host_xfer(input int m);
    logic [7:0] d, t, got;
    d = 8'($urandom);
    t = 8'($urandom);
    n_taken = 0;
    exp_q.push_back(d);
    cfg_mode <= csp_pkg::csp_cfg_mode_e'(2'(1 + m % 3));
    spi_mode <= csp_pkg::csp_spi_mode_s'(mtab[m]);
    sck_h    <= mtab[m][1];
    tx_byte  <= t;
    repeat (6) @(posedge core_clk);
    ss_h <= 1'b0;
    si_h <= d[7];
    repeat (6) @(posedge core_clk);
    // The first edge is a shift edge when polarity and phase differ (modes 1 and 2).
    for (int i = 7; i >= 0; i--) begin
      sck_h <= ~sck_h;
      if (^mtab[m]) si_h <= d[i];
      else got[i] = so_o;
      repeat (4) @(posedge core_clk);
      sck_h <= ~sck_h;
      if (^mtab[m]) got[i] = so_o;
      else if (i > 0) si_h <= d[i-1];
      repeat (4) @(posedge core_clk);
    end
    ss_h <= 1'b1;
    si_h <= ~si_h;
    check("slave byte", 32'(got), 32'(t));
    repeat (8) @(posedge core_clk);
    check("taken strobes", 32'(n_taken), 32'(1 + (mtab[m][1] == mtab[m][0])));
  endtask

  // Every received byte is matched against the model queue.
  always @(posedge core_clk) begin
    if (tx_taken === 1'b1) n_taken++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra byte", 32'(rd_data), 32'hffffffff);
      else check("received byte", 32'(rd_data), 32'(exp_q.pop_front()));
    end
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Clock of 100 MHz.
  always #5 core_clk = ~core_clk;

  // Main sequence.
  initial begin
    core_clk = 1'b0; rst = 1'b1; load_start = 1'b0; load_done = 1'b0; tx_byte = 8'h00;
    cfg_mode = csp_pkg::CSP_MODE_FLASH; spi_mode = 2'b00; flash_req = '0; base = 8'h00;
    sck_h = 1'b0; ss_h = 1'b1; si_h = 1'b0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    void'($urandom(63));
    for (m = 0; m < 4; m++) flash_load(m);
    flash_req <= '{8'h03, 24'h000000, 16'h0000};
    @(posedge core_clk);
    load_start <= 1'b1;
    @(posedge core_clk);
    load_start <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("empty load refused", 32'(ss_n_o), 32'h1);
    for (m = 0; m < 4; m++) host_xfer(m);
    repeat (4) begin
      sck_h <= ~sck_h;
      repeat (4) @(posedge core_clk);
      check("idle output enable", 32'(so_oe), 32'h0);
    end
    load_done <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("done pin high", 32'(config_done_pin), 32'h1);
    load_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("done pin low", 32'(config_done_pin), 32'h0);
    check("bytes left", 32'(exp_q.size()), 32'h0);
    print_verdict();
  end
endmodule
